/* File: design/acm_consts.vh */
// Constants for the access-control entry matcher: register map, field places, codes.
// Assumes byte addresses on a 32-bit APB with one register per aligned word.
`ifndef ACM_CONSTS_VH
`define ACM_CONSTS_VH

`define ACM_OFS_CTRL     8'h00
`define ACM_OFS_SA_LO    8'h04
`define ACM_OFS_SA_HI    8'h08
`define ACM_OFS_DA_LO    8'h0C
`define ACM_OFS_DA_HI    8'h10
`define ACM_OFS_VID      8'h14
`define ACM_OFS_SPA      8'h18
`define ACM_OFS_SPA_MSK  8'h1C
`define ACM_OFS_TPA      8'h20
`define ACM_OFS_TPA_MSK  8'h24
`define ACM_OFS_STATUS   8'h28
`define ACM_OFS_HITCNT   8'h2C

`define ACM_RST_WORD     32'h0000_0000

`define ACM_CTL_FTYPE    0
`define ACM_CTL_DENY     3
`define ACM_CTL_SA       4
`define ACM_CTL_DA       5
`define ACM_CTL_VID      8
`define ACM_CTL_PRIO_EN  9
`define ACM_CTL_PRIO     10
`define ACM_CTL_KIND     13
`define ACM_CTL_REQREP   15
`define ACM_CTL_SPA      17
`define ACM_CTL_TPA      19
`define ACM_CTL_SHA      21
`define ACM_CTL_THA      23
`define ACM_CTL_LEN      25
`define ACM_CTL_HRD      27
`define ACM_CTL_PRO      29

`define ACM_FT_ANY       3'h0
`define ACM_FT_ETYPE     3'h1
`define ACM_FT_ARP       3'h2
`define ACM_FT_IPV4      3'h3
`define ACM_FT_IPV6      3'h4

`define ACM_DA_ANY       3'h0
`define ACM_DA_GROUP     3'h1
`define ACM_DA_ALL       3'h2
`define ACM_DA_SINGLE    3'h3
`define ACM_DA_SPECIFIC  3'h4

`define ACM_KIND_ANY     2'h0
`define ACM_KIND_ARP     2'h1
`define ACM_KIND_RARP    2'h2
`define ACM_KIND_OTHER   2'h3

`define ACM_RR_ANY       2'h0
`define ACM_RR_REQ       2'h1
`define ACM_RR_REPLY     2'h2

`define ACM_IP_ANY       2'h0
`define ACM_IP_HOST      2'h1
`define ACM_IP_NET       2'h2

`define ACM_TRI_ANY      2'h0
`define ACM_TRI_ZERO     2'h1
`define ACM_TRI_ONE      2'h2

`define ACM_OP_ARP_REQ   16'h0001
`define ACM_OP_ARP_REP   16'h0002
`define ACM_OP_RARP_REQ  16'h0003
`define ACM_OP_RARP_REP  16'h0004
`define ACM_HRD_ETH      16'h0001
`define ACM_PRO_IP       16'h0800
`define ACM_HLN_ETH      8'h06
`define ACM_PLN_IP       8'h04
`define ACM_ALL_ONES     48'hFFFF_FFFF_FFFF

`endif

/* File: design/acm_arp_check.v */
// ARP and RARP payload criteria of one access-control entry, purely combinational.
// Assumes the parser presents every field steady while the frame is being judged.
`timescale 1ns/100ps
`include "acm_consts.vh"

module acm_arp_check (
   kind_sel,
   reqrep_sel,
   spa_mode,
   tpa_mode,
   sha_mode,
   tha_mode,
   len_mode,
   hrd_mode,
   pro_mode,
   spa_cfg,
   spa_msk,
   tpa_cfg,
   tpa_msk,
   arp_op,
   arp_hrd,
   arp_pro,
   arp_hln,
   arp_pln,
   arp_sha,
   arp_spa,
   arp_tha,
   arp_tpa,
   frm_sa,
   arp_ok
);
   input  wire [1:0]  kind_sel;
   input  wire [1:0]  reqrep_sel;
   input  wire [1:0]  spa_mode;
   input  wire [1:0]  tpa_mode;
   input  wire [1:0]  sha_mode;
   input  wire [1:0]  tha_mode;
   input  wire [1:0]  len_mode;
   input  wire [1:0]  hrd_mode;
   input  wire [1:0]  pro_mode;
   input  wire [31:0] spa_cfg;
   input  wire [31:0] spa_msk;
   input  wire [31:0] tpa_cfg;
   input  wire [31:0] tpa_msk;
   input  wire [15:0] arp_op;
   input  wire [15:0] arp_hrd;
   input  wire [15:0] arp_pro;
   input  wire [7:0]  arp_hln;
   input  wire [7:0]  arp_pln;
   input  wire [47:0] arp_sha;
   input  wire [31:0] arp_spa;
   input  wire [47:0] arp_tha;
   input  wire [31:0] arp_tpa;
   input  wire [47:0] frm_sa;
   output wire        arp_ok;

   // A reserved code behaves as don't-care rather than blocking every frame.
   function tri_ok;
      input [1:0] mode;
      input       cond;
      begin
         case (mode)
            `ACM_TRI_ZERO: tri_ok = ~cond;
            `ACM_TRI_ONE:  tri_ok = cond;
            default:       tri_ok = 1'b1;
         endcase
      end
   endfunction

   function ip_ok;
      input [1:0]  mode;
      input [31:0] fa;
      input [31:0] ca;
      input [31:0] mk;
      begin
         case (mode)
            `ACM_IP_HOST: ip_ok = (fa == ca);
            `ACM_IP_NET:  ip_ok = ((fa & mk) == (ca & mk));
            default:      ip_ok = 1'b1;
         endcase
      end
   endfunction

   wire op_arq = (arp_op == `ACM_OP_ARP_REQ);
   wire op_arp = (arp_op == `ACM_OP_ARP_REP);
   wire op_rrq = (arp_op == `ACM_OP_RARP_REQ);
   wire op_rrp = (arp_op == `ACM_OP_RARP_REP);
   wire is_arp = op_arq | op_arp;
   wire is_rarp = op_rrq | op_rrp;

   reg kind_ok;
   reg rr_ok;
   always @* begin
      case (kind_sel)
         `ACM_KIND_ARP:   kind_ok = is_arp;
         `ACM_KIND_RARP:  kind_ok = is_rarp;
         `ACM_KIND_OTHER: kind_ok = ~is_arp & ~is_rarp;
         default:         kind_ok = 1'b1;
      endcase
      case (reqrep_sel)
         `ACM_RR_REQ:   rr_ok = op_arq | op_rrq;
         `ACM_RR_REPLY: rr_ok = op_arp | op_rrp;
         default:       rr_ok = 1'b1;
      endcase
   end

   wire spa_ok = ip_ok(spa_mode, arp_spa, spa_cfg, spa_msk);
   wire tpa_ok = ip_ok(tpa_mode, arp_tpa, tpa_cfg, tpa_msk);
   wire sha_ok = tri_ok(sha_mode, arp_sha == frm_sa);
   // Non-RARP frames pass the target hardware check untouched.
   wire tha_ok = ~is_rarp | tri_ok(tha_mode, arp_tha == frm_sa);
   wire len_eq = (arp_hln == `ACM_HLN_ETH) & (arp_pln == `ACM_PLN_IP);
   wire len_ok = tri_ok(len_mode, len_eq);
   wire hrd_ok = tri_ok(hrd_mode, arp_hrd == `ACM_HRD_ETH);
   wire pro_ok = tri_ok(pro_mode, arp_pro == `ACM_PRO_IP);

   assign arp_ok = kind_ok & rr_ok & spa_ok & tpa_ok & sha_ok & tha_ok & len_ok & hrd_ok & pro_ok;
endmodule

/* File: design/acm_matcher.v */
// Match stage of one access-control entry with its APB register file.
// Assumes frame fields come from a parser on sys_clk, valid in the cycle of frm_valid.
`timescale 1ns/100ps
`include "acm_consts.vh"

// Notes on behaviour
// - Source address check only for entries of Ethernet-type or ARP frame type.
// - Source filter don't-care ignores address; specific needs full 48-bit equality.
// - Destination filter: don't-care, group, all-stations, single-station, or specific.
// - Specific destination filter hits only on exact 48-bit address equality.
// - VLAN filter don't-care or specific; specific needs equal identifier, 1 to 4095.
// - Priority filter holds 0 to 7 for equality, or don't-care.
// - Kind selector: don't-care, ARP, RARP, or other meaning unknown opcode.
// - Request/reply selector matches ARP or RARP request, or reply opcodes.
// - Sender protocol address: don't-care, host equality, or masked network equality.
// - Target protocol address: don't-care, host equality, or masked network equality.
// - Sender hardware address versus source address: equal, differ, or don't-care.
// - RARP target hardware address versus source address: equal, differ, or don't-care.
// - Length check wants hardware length 6 and protocol length 4; zero negates.
// - Hardware space check wants type 1; zero negates, don't-care ignores.
// - Protocol space check wants 0x800; zero negates, don't-care ignores.
// - Frame types exclusive; ARP and IP frames never match Ethernet-type entries.
// - A hit on a deny entry drops the frame.
module acm_matcher (
   sys_clk,
   arst_n,
   psel,
   penable,
   pwrite,
   paddr,
   pwdata,
   prdata,
   pready,
   pslverr,
   frm_valid,
   frm_kind,
   frm_sa,
   frm_da,
   frm_vid,
   frm_prio,
   arp_op,
   arp_hrd,
   arp_pro,
   arp_hln,
   arp_pln,
   arp_sha,
   arp_spa,
   arp_tha,
   arp_tpa,
   res_valid,
   ace_hit,
   ace_drop
);
   input  wire        sys_clk;
   input  wire        arst_n;
   input  wire        psel;
   input  wire        penable;
   input  wire        pwrite;
   input  wire [7:0]  paddr;
   input  wire [31:0] pwdata;
   output reg  [31:0] prdata;
   output reg         pready;
   output reg         pslverr;
   input  wire        frm_valid;
   input  wire [2:0]  frm_kind;
   input  wire [47:0] frm_sa;
   input  wire [47:0] frm_da;
   input  wire [11:0] frm_vid;
   input  wire [2:0]  frm_prio;
   input  wire [15:0] arp_op;
   input  wire [15:0] arp_hrd;
   input  wire [15:0] arp_pro;
   input  wire [7:0]  arp_hln;
   input  wire [7:0]  arp_pln;
   input  wire [47:0] arp_sha;
   input  wire [31:0] arp_spa;
   input  wire [47:0] arp_tha;
   input  wire [31:0] arp_tpa;
   output reg         res_valid;
   output reg         ace_hit;
   output reg         ace_drop;

   reg [31:0] ctrl_reg;
   reg [31:0] sa_lo_reg;
   reg [15:0] sa_hi_reg;
   reg [31:0] da_lo_reg;
   reg [15:0] da_hi_reg;
   reg [11:0] vid_reg;
   reg [31:0] spa_reg;
   reg [31:0] spa_msk_reg;
   reg [31:0] tpa_reg;
   reg [31:0] tpa_msk_reg;
   reg [31:0] hitcnt_reg;

   wire [2:0] ftype  = ctrl_reg[`ACM_CTL_FTYPE +: 3];
   wire       deny   = ctrl_reg[`ACM_CTL_DENY];
   wire       sa_en  = ctrl_reg[`ACM_CTL_SA];
   wire [2:0] da_sel = ctrl_reg[`ACM_CTL_DA +: 3];
   wire       vid_en = ctrl_reg[`ACM_CTL_VID];
   wire       pr_en  = ctrl_reg[`ACM_CTL_PRIO_EN];
   wire [2:0] pr_val = ctrl_reg[`ACM_CTL_PRIO +: 3];
   wire [47:0] sa_cfg = {sa_hi_reg, sa_lo_reg};
   wire [47:0] da_cfg = {da_hi_reg, da_lo_reg};

   // Setup cycle answers with pready in the next cycle, so every access takes one wait-free access phase.
   wire setup = psel & ~penable;
   wire acc_done = psel & penable & pready;
   wire wr_en = acc_done & pwrite;

   function mapped;
      input [7:0] a;
      begin
         case (a)
            `ACM_OFS_CTRL, `ACM_OFS_SA_LO, `ACM_OFS_SA_HI, `ACM_OFS_DA_LO,
            `ACM_OFS_DA_HI, `ACM_OFS_VID, `ACM_OFS_SPA, `ACM_OFS_SPA_MSK,
            `ACM_OFS_TPA, `ACM_OFS_TPA_MSK, `ACM_OFS_STATUS, `ACM_OFS_HITCNT: mapped = 1'b1;
            default: mapped = 1'b0;
         endcase
      end
   endfunction

   // Status is read-only; a write to it falls through the write decode and changes nothing.
   wire [31:0] status_word = {29'h0000_0000, ace_drop, ace_hit, res_valid};

   reg [31:0] rd_next;
   always @* begin
      case (paddr)
         `ACM_OFS_CTRL:    rd_next = ctrl_reg;
         `ACM_OFS_SA_LO:   rd_next = sa_lo_reg;
         `ACM_OFS_SA_HI:   rd_next = {16'h0000, sa_hi_reg};
         `ACM_OFS_DA_LO:   rd_next = da_lo_reg;
         `ACM_OFS_DA_HI:   rd_next = {16'h0000, da_hi_reg};
         `ACM_OFS_VID:     rd_next = {20'h00000, vid_reg};
         `ACM_OFS_SPA:     rd_next = spa_reg;
         `ACM_OFS_SPA_MSK: rd_next = spa_msk_reg;
         `ACM_OFS_TPA:     rd_next = tpa_reg;
         `ACM_OFS_TPA_MSK: rd_next = tpa_msk_reg;
         `ACM_OFS_STATUS:  rd_next = status_word;
         `ACM_OFS_HITCNT:  rd_next = hitcnt_reg;
         default:          rd_next = 32'h0000_0000;
      endcase
   end

   // Every answer comes one cycle after its setup; the bus never waits longer.
   // Read data is forced to zero outside a read answer so a stale word never leaks onto the bus.
   reg [31:0] prdata_next;
   reg        pready_next;
   reg        pslverr_next;
   always @* begin
      pready_next  = setup;
      pslverr_next = setup & ~mapped(paddr);
      prdata_next  = 32'h0000_0000;
      if (setup & ~pwrite) begin
         prdata_next = rd_next;
      end
   end

   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= pready_next;
         pslverr <= pslverr_next;
         prdata  <= prdata_next;
      end
   end

   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_reg    <= `ACM_RST_WORD;
         sa_lo_reg   <= `ACM_RST_WORD;
         sa_hi_reg   <= 16'h0000;
         da_lo_reg   <= `ACM_RST_WORD;
         da_hi_reg   <= 16'h0000;
         vid_reg     <= 12'h000;
         spa_reg     <= `ACM_RST_WORD;
         spa_msk_reg <= `ACM_RST_WORD;
         tpa_reg     <= `ACM_RST_WORD;
         tpa_msk_reg <= `ACM_RST_WORD;
      end else if (wr_en) begin
         case (paddr)
            `ACM_OFS_CTRL:    ctrl_reg    <= pwdata;
            `ACM_OFS_SA_LO:   sa_lo_reg   <= pwdata;
            `ACM_OFS_SA_HI:   sa_hi_reg   <= pwdata[15:0];
            `ACM_OFS_DA_LO:   da_lo_reg   <= pwdata;
            `ACM_OFS_DA_HI:   da_hi_reg   <= pwdata[15:0];
            `ACM_OFS_VID:     vid_reg     <= pwdata[11:0];
            `ACM_OFS_SPA:     spa_reg     <= pwdata;
            `ACM_OFS_SPA_MSK: spa_msk_reg <= pwdata;
            `ACM_OFS_TPA:     tpa_reg     <= pwdata;
            `ACM_OFS_TPA_MSK: tpa_msk_reg <= pwdata;
            default:          ctrl_reg    <= ctrl_reg;
         endcase
      end
   end

   reg type_ok;
   always @* begin
      case (ftype)
         `ACM_FT_ANY:   type_ok = 1'b1;
         `ACM_FT_ETYPE: type_ok = (frm_kind == `ACM_FT_ETYPE);
         `ACM_FT_ARP:   type_ok = (frm_kind == `ACM_FT_ARP);
         `ACM_FT_IPV4:  type_ok = (frm_kind == `ACM_FT_IPV4);
         `ACM_FT_IPV6:  type_ok = (frm_kind == `ACM_FT_IPV6);
         default:       type_ok = 1'b0;
      endcase
   end

   wire sa_applies = (ftype == `ACM_FT_ETYPE) | (ftype == `ACM_FT_ARP);
   wire sa_ok = ~sa_applies | ~sa_en | (frm_sa == sa_cfg);

   wire da_all = (frm_da == `ACM_ALL_ONES);
   wire da_grp = frm_da[40] & ~da_all;
   wire da_one = ~frm_da[40];
   reg da_ok;
   always @* begin
      case (da_sel)
         `ACM_DA_GROUP:    da_ok = da_grp;
         `ACM_DA_ALL:      da_ok = da_all;
         `ACM_DA_SINGLE:   da_ok = da_one;
         `ACM_DA_SPECIFIC: da_ok = (frm_da == da_cfg);
         default:          da_ok = 1'b1;
      endcase
   end

   // A configured identifier of zero can be written by software, but it never matches a tag.
   wire vid_ok = ~vid_en | ((vid_reg != 12'h000) & (frm_vid == vid_reg));
   wire pr_ok = ~pr_en | (frm_prio == pr_val);

   wire arp_ok;
   acm_arp_check u_arp (
      .kind_sel   (ctrl_reg[`ACM_CTL_KIND +: 2]),
      .reqrep_sel (ctrl_reg[`ACM_CTL_REQREP +: 2]),
      .spa_mode   (ctrl_reg[`ACM_CTL_SPA +: 2]),
      .tpa_mode   (ctrl_reg[`ACM_CTL_TPA +: 2]),
      .sha_mode   (ctrl_reg[`ACM_CTL_SHA +: 2]),
      .tha_mode   (ctrl_reg[`ACM_CTL_THA +: 2]),
      .len_mode   (ctrl_reg[`ACM_CTL_LEN +: 2]),
      .hrd_mode   (ctrl_reg[`ACM_CTL_HRD +: 2]),
      .pro_mode   (ctrl_reg[`ACM_CTL_PRO +: 2]),
      .spa_cfg    (spa_reg),
      .spa_msk    (spa_msk_reg),
      .tpa_cfg    (tpa_reg),
      .tpa_msk    (tpa_msk_reg),
      .arp_op     (arp_op),
      .arp_hrd    (arp_hrd),
      .arp_pro    (arp_pro),
      .arp_hln    (arp_hln),
      .arp_pln    (arp_pln),
      .arp_sha    (arp_sha),
      .arp_spa    (arp_spa),
      .arp_tha    (arp_tha),
      .arp_tpa    (arp_tpa),
      .frm_sa     (frm_sa),
      .arp_ok     (arp_ok)
   );

   // Payload criteria only count for ARP entries; other entries see them as don't-care.
   wire arp_term = (ftype != `ACM_FT_ARP) | arp_ok;
   wire hit_next = type_ok & sa_ok & da_ok & vid_ok & pr_ok & arp_term;
   // Only a frame that is being judged this cycle may move the hit counter.
   wire hit_now  = frm_valid & hit_next;
   wire cnt_clr  = wr_en & (paddr == `ACM_OFS_HITCNT);

   reg        res_valid_next;
   reg        ace_hit_next;
   reg        ace_drop_next;
   reg [31:0] hitcnt_next;
   always @* begin
      res_valid_next = frm_valid;
      ace_hit_next   = ace_hit;
      ace_drop_next  = ace_drop;
      hitcnt_next    = hitcnt_reg;
      // The verdict holds between frames so software can read it back at leisure.
      if (frm_valid) begin
         ace_hit_next  = hit_next;
         ace_drop_next = hit_next & deny;
      end
      // A clear that meets a hit keeps that hit, so no counted frame is lost.
      if (cnt_clr) begin
         hitcnt_next = hit_now ? 32'h0000_0001 : 32'h0000_0000;
      end else if (hit_now) begin
         hitcnt_next = hitcnt_reg + 32'h0000_0001;
      end
   end

   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         res_valid  <= 1'b0;
         ace_hit    <= 1'b0;
         ace_drop   <= 1'b0;
         hitcnt_reg <= `ACM_RST_WORD;
      end else begin
         res_valid  <= res_valid_next;
         ace_hit    <= ace_hit_next;
         ace_drop   <= ace_drop_next;
         hitcnt_reg <= hitcnt_next;
      end
   end
endmodule

/* File: testbench/acm_tb_types.svh */
// Frame record shared by the bench and the frame source model.
// Assumes field widths equal those of the matcher's frame ports.
`ifndef ACM_TB_TYPES_SVH
`define ACM_TB_TYPES_SVH
typedef struct packed {
   logic [2:0]  kind;
   logic [47:0] sa;
   logic [47:0] da;
   logic [11:0] vid;
   logic [2:0]  prio;
   logic [15:0] op;
   logic [15:0] hrd;
   logic [15:0] pro;
   logic [7:0]  hln;
   logic [7:0]  pln;
   logic [47:0] sha;
   logic [31:0] spa;
   logic [47:0] tha;
   logic [31:0] tpa;
} acm_frm_t;
`endif

/* File: testbench/acm_frame_src.sv */
// Behavioural ingress parser: presents one frame per call with a one-cycle valid.
// Assumes calls are made from the bench clock's domain, one per edge.
`timescale 1ns/100ps
`include "acm_tb_types.svh"
module acm_frame_src (
   input  wire logic sys_clk,
   output logic      frm_valid,
   output acm_frm_t  f
);
   initial begin
      frm_valid = 1'b0;
      f         = '0;
   end
   task automatic send(input acm_frm_t x);
      @(posedge sys_clk);
      frm_valid <= 1'b1;
      f         <= x;
   endtask
   // Fields invert once valid drops, so a matcher that samples late sees garbage.
   task automatic idle();
      @(posedge sys_clk);
      frm_valid <= 1'b0;
      f         <= ~f;
   endtask
endmodule

/* File: testbench/acm_matcher_sva.sv */
// Port checker for the entry matcher: bus handshake and verdict timing.
// Assumes one clock domain and the asynchronous active-low reset.
`timescale 1ns/100ps
module acm_matcher_sva (
   input wire        sys_clk,
   input wire        arst_n,
   input wire        psel,
   input wire        penable,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   input wire        frm_valid,
   input wire        res_valid,
   input wire        ace_hit,
   input wire        ace_drop
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   ready_after_setup_a: assert property (psel && !penable |=> pready)
      else $error("pready missing after setup");
   ready_in_access_a: assert property (pready |-> psel && penable)
      else $error("pready outside access phase");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   err_with_ready_a: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   rdata_idle_zero_a: assert property (!pready |-> prdata == 32'h0)
      else $error("prdata not zero when idle");
   result_follows_a: assert property (frm_valid |=> res_valid ##1 (!res_valid || $past(frm_valid)))
      else $error("res_valid not one cycle after frame");
   result_only_a: assert property (!frm_valid |=> !res_valid)
      else $error("res_valid without frame");
   // The verdict must survive idle cycles; the bench reads it several cycles later.
   verdict_hold_a: assert property (!frm_valid |=> $stable({ace_hit, ace_drop}))
      else $error("verdict changed without frame");
   drop_needs_hit_a: assert property (ace_drop |-> ace_hit)
      else $error("drop without hit");
endmodule
bind acm_matcher acm_matcher_sva chk (
   .sys_clk(sys_clk),
   .arst_n(arst_n),
   .psel(psel),
   .penable(penable),
   .prdata(prdata),
   .pready(pready),
   .pslverr(pslverr),
   .frm_valid(frm_valid),
   .res_valid(res_valid),
   .ace_hit(ace_hit),
   .ace_drop(ace_drop)
);

/* File: testbench/tb_top.sv */
// Self-checking bench: entry settings against edited frames, then bus and reset cases.
// Assumes the matcher answers APB in one access cycle and judges frames in one cycle.
`timescale 1ns/100ps
`include "acm_consts.vh"
`include "acm_tb_types.svh"
module tb_top;
   typedef struct packed {
      logic [31:0] c;
      logic [3:0]  s;
      logic [47:0] v;
      logic        h;
   } acm_row_t;
   logic        sys_clk, arst_n, psel, penable, pwrite, pready, pslverr, er;
   logic        frm_valid, res_valid, ace_hit, ace_drop;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   acm_frm_t    pf, base;
   int          fails, check_count, hits;
   logic [31:0] cfg_d [9] = '{32'h00000011, 32'h00000200, 32'h00000022, 32'h00000A00,
      32'h00000123, 32'hC0A80105, 32'hFFFFFF00, 32'hC0A80109, 32'hFFFF0000};
   acm_row_t    rows [40] = '{
      '{32'h00000000,4'h0,48'h0,1'h1},
      '{32'h00000001,4'h0,48'h0,1'h0},
      '{32'h00000001,4'h1,48'h1,1'h1},
      '{32'h00000004,4'h1,48'h4,1'h1},
      '{32'h00000003,4'h0,48'h0,1'h0},
      '{32'h00000012,4'h2,48'h020000000010,1'h0},
      '{32'h00000010,4'h2,48'h020000000010,1'h1},
      '{32'h00000020,4'h0,48'h0,1'h0},
      '{32'h00000020,4'h3,48'h010000000000,1'h1},
      '{32'h00000020,4'h3,48'hFFFFFFFFFFFF,1'h0},
      '{32'h00000040,4'h3,48'hFFFFFFFFFFFF,1'h1},
      '{32'h00000040,4'h3,48'hFFFFFFFFFFFE,1'h0},
      '{32'h00000060,4'h0,48'h0,1'h1},
      '{32'h00000080,4'h0,48'h0,1'h1},
      '{32'h00000080,4'h3,48'h8A0000000022,1'h0},
      '{32'h00000100,4'h0,48'h0,1'h1},
      '{32'h00000100,4'h4,48'h122,1'h0},
      '{32'h00001E00,4'h5,48'h7,1'h1},
      '{32'h00001600,4'h5,48'h4,1'h0},
      '{32'h00002002,4'h0,48'h0,1'h1},
      '{32'h00004002,4'h6,48'h4,1'h1},
      '{32'h00006002,4'h6,48'h5,1'h1},
      '{32'h00006002,4'h6,48'h3,1'h0},
      '{32'h00008002,4'h6,48'h3,1'h1},
      '{32'h00010002,4'h6,48'h1,1'h0},
      '{32'h00040002,4'hC,48'hC0A801FE,1'h1},
      '{32'h00020002,4'hC,48'hC0A80106,1'h0},
      '{32'h00100002,4'hE,48'hC0A8FFFF,1'h1},
      '{32'h00080002,4'hE,48'hC0A8010A,1'h0},
      '{32'h00200002,4'hB,48'h0,1'h1},
      '{32'h00400002,4'hB,48'h0,1'h0},
      '{32'h01000002,4'h6,48'h3,1'h1},
      '{32'h00800002,4'h6,48'h4,1'h0},
      '{32'h04000002,4'h9,48'h5,1'h0},
      '{32'h02000002,4'hA,48'h10,1'h1},
      '{32'h10000002,4'h7,48'h6,1'h0},
      '{32'h08000002,4'h7,48'h6,1'h1},
      '{32'h40000002,4'h8,48'h86DD,1'h0},
      '{32'h20000002,4'h0,48'h0,1'h0},
      '{32'h0000000A,4'h0,48'h0,1'h1}};
   acm_matcher uut (.sys_clk(sys_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .frm_valid(frm_valid), .frm_kind(pf.kind), .frm_sa(pf.sa),
      .frm_da(pf.da), .frm_vid(pf.vid), .frm_prio(pf.prio), .arp_op(pf.op), .arp_hrd(pf.hrd),
      .arp_pro(pf.pro), .arp_hln(pf.hln), .arp_pln(pf.pln), .arp_sha(pf.sha), .arp_spa(pf.spa),
      .arp_tha(pf.tha), .arp_tpa(pf.tpa), .res_valid(res_valid), .ace_hit(ace_hit),
      .ace_drop(ace_drop));
   acm_frame_src src (.sys_clk(sys_clk), .frm_valid(frm_valid), .f(pf));
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   task automatic chk(input string n, input logic [47:0] s, input logic [47:0] e);
      check_count++;
      if (s !== e) begin
         fails++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge sys_clk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) begin
         fails++;
         wrap_up();
      end
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   function automatic acm_frm_t edit(input logic [3:0] s, input logic [47:0] v);
      acm_frm_t x;
      x = base;
      case (s)
         4'h1: x.kind = v[2:0];
         4'h2: x.sa = v;
         4'h3: x.da = v;
         4'h4: x.vid = v[11:0];
         4'h5: x.prio = v[2:0];
         4'h6: x.op = v[15:0];
         4'h7: x.hrd = v[15:0];
         4'h8: x.pro = v[15:0];
         4'h9: x.hln = v[7:0];
         4'hA: x.pln = v[7:0];
         4'hB: x.sha = v;
         4'hC: x.spa = v[31:0];
         4'hE: x.tpa = v[31:0];
         default: ;
      endcase
      return x;
   endfunction
   task automatic judge(input acm_frm_t x, input logic h, input logic dn);
      src.send(x);
      src.idle();
      #1;
      chk("res_valid", res_valid, 1'b1);
      chk("ace_hit", ace_hit, h);
      chk("ace_drop", ace_drop, h & dn);
   endtask
   initial begin
      arst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      fails = 0;
      check_count = 0;
      hits = 0;
      base = '{3'h2, 48'h020000000011, 48'h0A0000000022, 12'h123, 3'h5, `ACM_OP_ARP_REQ,
         `ACM_HRD_ETH, `ACM_PRO_IP, `ACM_HLN_ETH, `ACM_PLN_IP, 48'h020000000011,
         32'hC0A80105, 48'h020000000011, 32'hC0A80109};
      repeat (16) @(posedge sys_clk);
      arst_n <= 1'b1;
      for (int i = 0; i < 9; i++)
         apb(1'b1, 8'(4 * i + 4), cfg_d[i]);
      foreach (rows[i]) begin
         apb(1'b1, `ACM_OFS_CTRL, rows[i].c);
         judge(edit(rows[i].s, rows[i].v), rows[i].h, rows[i].c[3]);
         hits += rows[i].h;
      end
      apb(1'b0, `ACM_OFS_HITCNT, 32'h0);
      chk("hit count", rd, 48'(hits));
      src.send(edit(4'h1, 48'h1));
      src.send(base);
      #1;
      chk("first ace_hit", ace_hit, 1'b0);
      src.idle();
      #1;
      chk("second ace_drop", ace_drop, 1'b1);
      apb(1'b1, `ACM_OFS_STATUS, 32'hFFFFFFFF);
      apb(1'b0, `ACM_OFS_STATUS, 32'h0);
      chk("status", rd, 48'h6);
      apb(1'b0, 8'h30, 32'h0);
      chk("unmapped error", er, 1'b1);
      chk("unmapped data", rd, 48'h0);
      apb(1'b1, `ACM_OFS_HITCNT, 32'h0);
      apb(1'b0, `ACM_OFS_HITCNT, 32'h0);
      chk("cleared hit count", rd, 48'h0);
      judge(base, 1'b1, 1'b1);
      @(posedge sys_clk);
      arst_n <= 1'b0;
      repeat (3) @(posedge sys_clk);
      chk("reset ace_hit", ace_hit, 1'b0);
      arst_n <= 1'b1;
      apb(1'b0, `ACM_OFS_CTRL, 32'h0);
      chk("reset ctrl", rd, 48'h0);
      apb(1'b0, `ACM_OFS_HITCNT, 32'h0);
      chk("reset hit count", rd, 48'h0);
      wrap_up();
   end
endmodule
